// [verilog/uho_cmd_top.sv]
`timescale 1ns/10ps
module uho_cmd_top #(
	parameter int         NUM_UVARS   = 16,
	parameter logic [7:0] MODULE_ADDR = 8'h01,
	parameter logic [7:0] HOST_ADDR   = 8'h02
) (
	input  logic                          clk_i,
	input  logic                          rst_i,
	input  logic                          wb_cyc_i,
	input  logic                          wb_stb_i,
	input  logic                          wb_we_i,
	input  logic [uho_pkg::WB_AW-1:0]     wb_adr_i,
	input  logic [uho_pkg::WB_DW-1:0]     wb_dat_i,
	input  logic [3:0]                    wb_sel_i,
	output logic [uho_pkg::WB_DW-1:0]     wb_dat_o,
	output logic                          wb_ack_o,
	input  logic [31:0]                   accum_i,
	input  logic                          homing_active_i,
	output logic                          homing_start_o,
	output logic                          homing_stop_o,
	output logic [uho_pkg::NUM_OUTS-1:0]  dig_out_o,
	output logic [uho_pkg::NUM_PULLUPS-1:0] pullup_en_o,
	output logic                          nv_req_o,
	output logic                          nv_we_o,
	output logic [$clog2(NUM_UVARS)-1:0]  nv_addr_o,
	output logic [31:0]                   nv_wdata_o,
	input  logic [31:0]                   nv_rdata_i,
	input  logic                          nv_ack_i
);
	import uho_pkg::*;

	localparam int         IDXW     = $clog2(NUM_UVARS);
	localparam logic [8:0] UV_LIMIT = 9'(NUM_UVARS);

	typedef enum logic [1:0] {
		EX_IDLE = 2'b00,
		EX_NV   = 2'b01
	} uho_ex_state_e;

	uho_uvar_if #(.IDXW(IDXW)) uv ();

	logic            wb_req;
	logic            stall;
	logic            go;
	logic            ack_r;
	logic [31:0]     dat_r;
	logic            frm_valid;
	logic            f_chk_ok;
	logic [7:0]      f_addr;
	logic [7:0]      f_instr;
	logic [7:0]      f_type;
	logic [7:0]      f_bank;
	logic [31:0]     f_value;
	logic            exec;
	logic            busy;
	uho_ex_state_e   ex_state_r;
	logic [7:0]      dout_r;
	logic [5:0]      pullup_r;
	logic            start_r;
	logic            stop_r;
	logic            rep_valid_r;
	logic [7:0]      rep_status_r;
	logic [7:0]      rep_instr_r;
	logic [31:0]     rep_value_r;
	logic [7:0]      rep_chk;
	logic [IDXW-1:0] uvsel_r;
	logic [31:0]     uv_merge;
	logic [31:0]     rd_mux;
	logic [7:0]      d_status;
	logic [31:0]     d_value;
	logic            d_uv;
	uho_uv_op_e      d_op;
	logic [7:0]      d_out;
	logic [5:0]      d_pull;
	logic            d_start;
	logic            d_stop;
	logic            rep_load;
	logic            sw_uv_wr;

	// ------------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------------
	assign wb_req = wb_cyc_i && wb_stb_i;
	assign busy   = ex_state_r != EX_IDLE || uv.busy || frm_valid;
	assign stall  = busy && wb_we_i
		&& (wb_adr_i == ADDR_FRAME || wb_adr_i == ADDR_UVAR_DATA);
	assign go     = wb_req && !ack_r && !stall;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_r <= 1'b0;
		else
			ack_r <= go;
	end

	always_comb
	begin
		rd_mux = 32'h00000000;
		unique case (wb_adr_i)
			ADDR_STATUS:
			begin
				rd_mux[ST_REPLY_BIT] = rep_valid_r;
				rd_mux[ST_BUSY_BIT]  = busy;
				rd_mux[ST_BOOT_BIT]  = uv.boot_done;
			end
			ADDR_REPLY_HDR: rd_mux = {HOST_ADDR, MODULE_ADDR,
				rep_status_r, rep_instr_r};
			ADDR_REPLY_VAL: rd_mux = rep_value_r;
			ADDR_UVAR_SEL:  rd_mux[IDXW-1:0] = uvsel_r;
			ADDR_UVAR_DATA: rd_mux = uv.rd_data;
			ADDR_OUTPUTS:
			begin
				rd_mux[NUM_OUTS-1:0] = dout_r;
				rd_mux[OUTS_PULL_LSB +: NUM_PULLUPS] = pullup_r;
			end
			ADDR_REPLY_CHK: rd_mux[7:0] = rep_chk;
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_r <= 32'h00000000;
		else if (go && !wb_we_i)
			dat_r <= rd_mux;
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			uvsel_r <= '0;
		else if (go && wb_we_i && wb_adr_i == ADDR_UVAR_SEL && wb_sel_i[0])
			uvsel_r <= wb_dat_i[IDXW-1:0];
	end

	always_comb
	begin
		for (int b = 0; b < 4; b++)
			uv_merge[8*b +: 8] = wb_sel_i[b] ? wb_dat_i[8*b +: 8]
				: uv.rd_data[8*b +: 8];
	end

	assign sw_uv_wr = go && wb_we_i && wb_adr_i == ADDR_UVAR_DATA;

	// ------------------------------------------------------------------
	// Frame reception
	// ------------------------------------------------------------------
	uho_frame_rx u_rx (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.clear_i      (go && wb_we_i && wb_adr_i == ADDR_STATUS
			&& wb_dat_i[CTL_FRM_CLR_BIT]),
		.byte_i       (wb_dat_i[7:0]),
		.byte_valid_i (go && wb_we_i && wb_adr_i == ADDR_FRAME
			&& wb_sel_i[0]),
		.frm_valid_o  (frm_valid),
		.chk_ok_o     (f_chk_ok),
		.addr_o       (f_addr),
		.instr_o      (f_instr),
		.type_o       (f_type),
		.bank_o       (f_bank),
		.value_o      (f_value)
	);

	assign exec = frm_valid && f_addr == MODULE_ADDR;

	// ------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------
	always_comb
	begin
		d_status = STAT_OK;
		d_value  = 32'h00000000;
		d_uv     = 1'b0;
		d_op     = UV_OP_STORE;
		d_out    = dout_r;
		d_pull   = pullup_r;
		d_start  = 1'b0;
		d_stop   = 1'b0;
		if (!f_chk_ok)
			d_status = STAT_CHK_ERR;
		else
			unique case (f_instr)
				INSTR_STORE_UV, INSTR_RESTORE_UV:
					if (f_bank != BANK_UVAR)
						d_status = STAT_BAD_VALUE;
					else if ({1'b0, f_type} >= UV_LIMIT)
						d_status = STAT_BAD_TYPE;
					else
					begin
						d_uv = 1'b1;
						d_op = (f_instr == INSTR_STORE_UV) ? UV_OP_STORE
							: UV_OP_RESTORE;
					end
				INSTR_HOMING:
					if (f_bank != MOTOR_ZERO)
						d_status = STAT_BAD_VALUE;
					else if (f_type == HOME_START)
						d_start = 1'b1;
					else if (f_type == HOME_STOP)
						d_stop = 1'b1;
					else if (f_type == HOME_STATUS)
						d_value = {31'h00000000, homing_active_i};
					else
						d_status = STAT_BAD_TYPE;
				INSTR_SET_OUT:
					if (f_bank == BANK_OUTPUTS)
					begin
						if (f_type == PORT_ALL && f_value == VALUE_FROM_ACCUM)
							d_out = accum_i[7:0];
						else if (f_type == PORT_ALL && f_value[31:8] == 24'h0)
							d_out = f_value[7:0];
						else if (f_type == PORT_ALL)
							d_status = STAT_BAD_VALUE;
						else if (f_type >= PORT_COUNT)
							d_status = STAT_BAD_TYPE;
						else if (f_value[31:1] != 31'h0)
							d_status = STAT_BAD_VALUE;
						else
							d_out[f_type[2:0]] = f_value[0];
					end
					else if (f_bank == BANK_PULLUP)
					begin
						if (f_type != PORT_PULLUP)
							d_status = STAT_BAD_TYPE;
						else if (f_value[31:6] != 26'h0)
							d_status = STAT_BAD_VALUE;
						else
							d_pull = f_value[5:0];
					end
					else
						d_status = STAT_BAD_VALUE;
				default: d_status = STAT_BAD_CMD;
			endcase
	end

	// ------------------------------------------------------------------
	// Execution and user-variable requests
	// ------------------------------------------------------------------
	assign uv.cmd_valid = (exec && ex_state_r == EX_IDLE && d_uv) || sw_uv_wr;
	assign uv.op        = sw_uv_wr ? UV_OP_WRITE : d_op;
	assign uv.idx       = sw_uv_wr ? uvsel_r : f_type[IDXW-1:0];
	assign uv.wdata     = uv_merge;
	assign uv.rd_idx    = uvsel_r;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ex_state_r <= EX_IDLE;
		else
			unique case (ex_state_r)
				EX_IDLE: if (exec && d_uv)
					ex_state_r <= EX_NV;
				EX_NV: if (uv.done)
					ex_state_r <= EX_IDLE;
			endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			dout_r   <= OUTS_RESET;
			pullup_r <= PULLUP_RESET;
			start_r  <= 1'b0;
			stop_r   <= 1'b0;
		end
		else
		begin
			start_r <= exec && d_start;
			stop_r  <= exec && d_stop;
			if (exec)
			begin
				dout_r   <= d_out;
				pullup_r <= d_pull;
			end
		end
	end

	assign homing_start_o = start_r;
	assign homing_stop_o  = stop_r;
	assign dig_out_o      = dout_r;
	assign pullup_en_o    = pullup_r;

	// ------------------------------------------------------------------
	// Reply
	// ------------------------------------------------------------------
	assign rep_load = (exec && !d_uv) || (ex_state_r == EX_NV && uv.done);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rep_status_r <= 8'h00;
			rep_instr_r  <= 8'h00;
			rep_value_r  <= 32'h00000000;
		end
		else if (rep_load)
		begin
			rep_instr_r  <= f_instr;
			rep_status_r <= (ex_state_r == EX_NV) ? STAT_OK : d_status;
			rep_value_r  <= (ex_state_r == EX_NV) ? 32'h0 : d_value;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rep_valid_r <= 1'b0;
		else if (rep_load)
			rep_valid_r <= 1'b1;
		else if (go && wb_we_i && wb_adr_i == ADDR_STATUS
			&& wb_dat_i[ST_REPLY_BIT])
			rep_valid_r <= 1'b0;
	end

	assign rep_chk = HOST_ADDR + MODULE_ADDR + rep_status_r + rep_instr_r
		+ rep_value_r[31:24] + rep_value_r[23:16] + rep_value_r[15:8]
		+ rep_value_r[7:0];

	// ------------------------------------------------------------------
	// User-variable store
	// ------------------------------------------------------------------
	uho_uvar_store #(.NUM_UVARS(NUM_UVARS), .IDXW(IDXW)) u_uv (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.uv         (uv.store),
		.nv_req_o   (nv_req_o),
		.nv_we_o    (nv_we_o),
		.nv_addr_o  (nv_addr_o),
		.nv_wdata_o (nv_wdata_o),
		.nv_rdata_i (nv_rdata_i),
		.nv_ack_i   (nv_ack_i)
	);

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_store_issue: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && f_chk_ok && f_instr == INSTR_STORE_UV && f_bank == BANK_UVAR
		&& {1'b0, f_type} < UV_LIMIT && ex_state_r == EX_IDLE |->
		uv.cmd_valid && uv.op == UV_OP_STORE ##1 ex_state_r == EX_NV)
		else $error("Store command did not start a store.");

	a_nv_reply_ok: assert property (@(posedge clk_i) disable iff (rst_i)
		ex_state_r == EX_NV && uv.done |=>
		rep_valid_r && rep_status_r == STAT_OK && rep_value_r == 32'h0)
		else $error("Store or reload reply is not OK with zero.");

	a_home_start: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && f_chk_ok && f_instr == INSTR_HOMING && f_bank == MOTOR_ZERO
		&& f_type == HOME_START |=> homing_start_o && !homing_stop_o
		&& rep_status_r == STAT_OK && rep_value_r == 32'h0)
		else $error("Homing start not issued or reply wrong.");

	a_home_query: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && f_chk_ok && f_instr == INSTR_HOMING && f_bank == MOTOR_ZERO
		&& f_type == HOME_STATUS |=>
		(rep_value_r != 32'h0) == $past(homing_active_i))
		else $error("Homing status reply does not follow search state.");

	a_out_single: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && f_chk_ok && f_instr == INSTR_SET_OUT && f_bank == BANK_OUTPUTS
		&& f_type < PORT_COUNT && f_value < 32'h2 |=>
		dig_out_o[$past(f_type[2:0])] == $past(f_value[0]))
		else $error("Single output not set to requested level.");

	a_out_vector: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && f_chk_ok && f_instr == INSTR_SET_OUT && f_bank == BANK_OUTPUTS
		&& f_type == PORT_ALL && f_value < 32'h100 |=>
		dig_out_o == $past(f_value[7:0]))
		else $error("Output vector not applied.");

	a_out_accum: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && f_chk_ok && f_instr == INSTR_SET_OUT && f_bank == BANK_OUTPUTS
		&& f_type == PORT_ALL && f_value == VALUE_FROM_ACCUM |=>
		dig_out_o == $past(accum_i[7:0]))
		else $error("Outputs not taken from accumulator.");

	a_pullup_load: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && f_chk_ok && f_instr == INSTR_SET_OUT && f_bank == BANK_PULLUP
		&& f_type == PORT_PULLUP && f_value < 32'h40 |=>
		pullup_en_o == $past(f_value[5:0]))
		else $error("Pull-up vector not loaded.");

	a_pullup_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> pullup_en_o == PULLUP_RESET)
		else $error("Pull-ups not all enabled after reset.");

	a_chk_reject: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && !f_chk_ok |=> rep_status_r == STAT_CHK_ERR
		&& dig_out_o == $past(dig_out_o) && !homing_start_o)
		else $error("Bad checksum frame was executed.");

endmodule : uho_cmd_top

// [verilog/uho_pkg.sv]
package uho_pkg;

	// ------------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------------
	localparam int WB_AW       = 8;
	localparam int WB_DW       = 32;
	localparam int NUM_OUTS    = 8;
	localparam int NUM_PULLUPS = 6;

	// ------------------------------------------------------------------
	// Frame layout and command codes
	// ------------------------------------------------------------------
	localparam logic [3:0]  FRAME_LAST       = 4'h8;
	localparam logic [3:0]  POS_ADDR         = 4'h0;
	localparam logic [3:0]  POS_INSTR        = 4'h1;
	localparam logic [3:0]  POS_TYPE         = 4'h2;
	localparam logic [3:0]  POS_BANK         = 4'h3;
	localparam logic [7:0]  INSTR_STORE_UV   = 8'h0B;
	localparam logic [7:0]  INSTR_RESTORE_UV = 8'h0C;
	localparam logic [7:0]  INSTR_HOMING     = 8'h0D;
	localparam logic [7:0]  INSTR_SET_OUT    = 8'h0E;
	localparam logic [7:0]  BANK_UVAR        = 8'h02;
	localparam logic [7:0]  BANK_OUTPUTS     = 8'h02;
	localparam logic [7:0]  BANK_PULLUP      = 8'h00;
	localparam logic [7:0]  MOTOR_ZERO       = 8'h00;
	localparam logic [7:0]  HOME_START       = 8'h00;
	localparam logic [7:0]  HOME_STOP        = 8'h01;
	localparam logic [7:0]  HOME_STATUS      = 8'h02;
	localparam logic [7:0]  PORT_ALL         = 8'hFF;
	localparam logic [7:0]  PORT_PULLUP      = 8'h00;
	localparam logic [7:0]  PORT_COUNT       = 8'h08;
	localparam logic [31:0] VALUE_FROM_ACCUM = 32'hFFFFFFFF;

	// ------------------------------------------------------------------
	// Reply status codes and reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] STAT_OK        = 8'h64;
	localparam logic [7:0] STAT_CHK_ERR   = 8'h01;
	localparam logic [7:0] STAT_BAD_CMD   = 8'h02;
	localparam logic [7:0] STAT_BAD_TYPE  = 8'h03;
	localparam logic [7:0] STAT_BAD_VALUE = 8'h04;
	localparam logic [5:0] PULLUP_RESET   = 6'h3F;
	localparam logic [7:0] OUTS_RESET     = 8'h00;

	// ------------------------------------------------------------------
	// Register map (byte addresses) and fields
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_FRAME      = 8'h00;
	localparam logic [7:0] ADDR_STATUS     = 8'h04;
	localparam logic [7:0] ADDR_REPLY_HDR  = 8'h08;
	localparam logic [7:0] ADDR_REPLY_VAL  = 8'h0C;
	localparam logic [7:0] ADDR_UVAR_SEL   = 8'h10;
	localparam logic [7:0] ADDR_UVAR_DATA  = 8'h14;
	localparam logic [7:0] ADDR_OUTPUTS    = 8'h18;
	localparam logic [7:0] ADDR_REPLY_CHK  = 8'h1C;
	localparam int         ST_REPLY_BIT    = 0;
	localparam int         ST_BUSY_BIT     = 1;
	localparam int         ST_BOOT_BIT     = 2;
	localparam int         CTL_FRM_CLR_BIT = 1;
	localparam int         OUTS_PULL_LSB   = 8;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		UV_OP_STORE   = 2'b00,
		UV_OP_RESTORE = 2'b01,
		UV_OP_WRITE   = 2'b10
	} uho_uv_op_e;

endpackage : uho_pkg

// [verilog/uho_uvar_if.sv]
`timescale 1ns/10ps
interface uho_uvar_if #(parameter int IDXW = 4);
	logic                   cmd_valid;
	uho_pkg::uho_uv_op_e    op;
	logic [IDXW-1:0]        idx;
	logic [31:0]            wdata;
	logic [IDXW-1:0]        rd_idx;
	logic [31:0]            rd_data;
	logic                   busy;
	logic                   done;
	logic                   boot_done;

	modport ctrl (output cmd_valid, op, idx, wdata, rd_idx,
		input busy, done, boot_done, rd_data);
	modport store (input cmd_valid, op, idx, wdata, rd_idx,
		output busy, done, boot_done, rd_data);
endinterface : uho_uvar_if

// [verilog/uho_frame_rx.sv]
`timescale 1ns/10ps
module uho_frame_rx (
	input  logic        clk_i,
	input  logic        rst_i,
	input  logic        clear_i,
	input  logic [7:0]  byte_i,
	input  logic        byte_valid_i,
	output logic        frm_valid_o,
	output logic        chk_ok_o,
	output logic [7:0]  addr_o,
	output logic [7:0]  instr_o,
	output logic [7:0]  type_o,
	output logic [7:0]  bank_o,
	output logic [31:0] value_o
);
	import uho_pkg::*;

	logic [3:0] cnt_r;
	logic [7:0] sum_r;

	// ------------------------------------------------------------------
	// Byte assembly
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i || clear_i)
		begin
			cnt_r <= 4'h0;
			sum_r <= 8'h00;
		end
		else if (byte_valid_i)
		begin
			cnt_r <= (cnt_r == FRAME_LAST) ? 4'h0 : cnt_r + 4'h1;
			sum_r <= (cnt_r == FRAME_LAST) ? 8'h00 : sum_r + byte_i;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			addr_o  <= 8'h00;
			instr_o <= 8'h00;
			type_o  <= 8'h00;
			bank_o  <= 8'h00;
			value_o <= 32'h00000000;
		end
		else if (byte_valid_i && !clear_i)
		begin
			unique case (cnt_r)
				POS_ADDR:  addr_o  <= byte_i;
				POS_INSTR: instr_o <= byte_i;
				POS_TYPE:  type_o  <= byte_i;
				POS_BANK:  bank_o  <= byte_i;
				FRAME_LAST: ;
				default:   value_o <= {value_o[23:0], byte_i};
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			frm_valid_o <= 1'b0;
			chk_ok_o    <= 1'b0;
		end
		else
		begin
			frm_valid_o <= byte_valid_i && !clear_i && cnt_r == FRAME_LAST;
			if (byte_valid_i && cnt_r == FRAME_LAST)
				chk_ok_o <= (sum_r == byte_i);
		end
	end

	a_chk_compare: assert property (@(posedge clk_i) disable iff (rst_i)
		byte_valid_i && !clear_i && cnt_r == FRAME_LAST |=>
		frm_valid_o && chk_ok_o == ($past(sum_r) == $past(byte_i)))
		else $error("Checksum verdict does not match byte sum.");

endmodule : uho_frame_rx

// [verilog/uho_uvar_store.sv]
`timescale 1ns/10ps
module uho_uvar_store #(
	parameter int NUM_UVARS = 16,
	parameter int IDXW      = 4
) (
	input  logic            clk_i,
	input  logic            rst_i,
	uho_uvar_if.store       uv,
	output logic            nv_req_o,
	output logic            nv_we_o,
	output logic [IDXW-1:0] nv_addr_o,
	output logic [31:0]     nv_wdata_o,
	input  logic [31:0]     nv_rdata_i,
	input  logic            nv_ack_i
);
	import uho_pkg::*;

	typedef enum logic [1:0] {
		UVS_BOOT    = 2'b00,
		UVS_IDLE    = 2'b01,
		UVS_STORE   = 2'b10,
		UVS_RESTORE = 2'b11
	} uho_uvs_state_e;

	localparam logic [IDXW-1:0] LAST_IDX = IDXW'(NUM_UVARS - 1);

	uho_uvs_state_e  state_r;
	logic [IDXW-1:0] idx_r;
	logic            done_r;
	logic            boot_done_r;
	logic [31:0]     vars_r [NUM_UVARS];

	// ------------------------------------------------------------------
	// Sequencer for boot reload and single store or reload
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r     <= UVS_BOOT;
			idx_r       <= '0;
			done_r      <= 1'b0;
			boot_done_r <= 1'b0;
		end
		else
		begin
			done_r <= 1'b0;
			unique case (state_r)
				UVS_BOOT:
					if (nv_ack_i)
					begin
						if (idx_r == LAST_IDX)
						begin
							state_r     <= UVS_IDLE;
							boot_done_r <= 1'b1;
						end
						idx_r <= idx_r + 1'b1;
					end
				UVS_IDLE:
					if (uv.cmd_valid && uv.op != UV_OP_WRITE)
					begin
						idx_r   <= uv.idx;
						state_r <= (uv.op == UV_OP_STORE) ? UVS_STORE
							: UVS_RESTORE;
					end
				UVS_STORE, UVS_RESTORE:
					if (nv_ack_i)
					begin
						state_r <= UVS_IDLE;
						done_r  <= 1'b1;
					end
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if ((state_r == UVS_BOOT || state_r == UVS_RESTORE) && nv_ack_i)
			vars_r[idx_r] <= nv_rdata_i;
		else if (state_r == UVS_IDLE && uv.cmd_valid
			&& uv.op == UV_OP_WRITE)
			vars_r[uv.idx] <= uv.wdata;
	end

	assign nv_req_o     = state_r != UVS_IDLE;
	assign nv_we_o      = state_r == UVS_STORE;
	assign nv_addr_o    = idx_r;
	assign nv_wdata_o   = vars_r[idx_r];
	assign uv.busy      = state_r != UVS_IDLE;
	assign uv.done      = done_r;
	assign uv.boot_done = boot_done_r;
	assign uv.rd_data   = vars_r[uv.rd_idx];

	a_boot_reload: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == UVS_BOOT && nv_ack_i && idx_r == LAST_IDX |=>
		boot_done_r && state_r == UVS_IDLE && !nv_req_o)
		else $error("Boot reload did not finish after last variable.");

endmodule : uho_uvar_store

// [dv/uho_nv_model.sv]
`timescale 1ns/10ps
module uho_nv_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        req_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	output logic      [31:0] rdata_o = 32'h0,
	output logic             ack_o = 1'b0
);
	logic [31:0] mem [16];
	logic        half_r = 1'b0;
	initial
	begin
		for (int i = 0; i < 16; i++) mem[i] = 32'hA5000000 + i;
	end
	// Answers in the second cycle of a request; read data toggles otherwise.
	always @(posedge clk_i)
	begin
		ack_o <= 1'b0;
		rdata_o <= ~rdata_o;
		half_r <= req_i && !ack_o && !half_r && !rst_i;
		if (half_r && req_i)
		begin
			ack_o <= 1'b1;
			rdata_o <= mem[addr_i];
			if (we_i) mem[addr_i] <= wdata_i;
		end
	end
endmodule : uho_nv_model

// [dv/uho_cmd_top_test.sv]
`timescale 1ns/10ps
module uho_cmd_top_test;
	import uho_pkg::*;
	logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, hact = 0;
	logic [7:0]  adr = 8'h00, dout;
	logic [31:0] wdat = 32'h0, accum = 32'h0, rd, rdata, val, nwd, nrd;
	logic [5:0]  pull;
	logic [3:0]  naddr;
	logic        ack, hst, hsp, nreq, nwe, nack;
	int          err_count = 0, samples_checked = 0, starts = 0, stops = 0;
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		starts += hst;
		stops += hsp;
	end
	uho_cmd_top uho_cmd_top_inst (.clk_i, .rst_i, .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_sel_i(4'hF), .wb_dat_o(rdata), .wb_ack_o(ack), .accum_i(accum),
		.homing_active_i(hact), .homing_start_o(hst), .homing_stop_o(hsp),
		.dig_out_o(dout), .pullup_en_o(pull), .nv_req_o(nreq), .nv_we_o(nwe),
		.nv_addr_o(naddr), .nv_wdata_o(nwd), .nv_rdata_i(nrd), .nv_ack_i(nack));
	uho_nv_model uho_nv_model_inst (.clk_i, .rst_i, .req_i(nreq), .we_i(nwe),
		.addr_i(naddr), .wdata_i(nwd), .rdata_o(nrd), .ack_o(nack));
	task automatic check(input string n, input logic [31:0] s, e);
		samples_checked++;
		if (s !== e)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	// ----------------------------------------------------------------
	// Bus cycle and command frame
	// ----------------------------------------------------------------
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 3000);
		rd = rdata;
		{cyc, stb} <= 2'b00;
		if (n >= 3000) err_count++;
	endtask : wb
	task automatic frame(input logic [7:0] ins, ty, bk, input logic [31:0] v,
		input logic [7:0] st, bad);
		logic [7:0] b [9];
		int         n;
		logic [7:0] c;
		b = '{8'h01, ins, ty, bk, v[31:24], v[23:16], v[15:8], v[7:0], bad};
		n = 0;
		for (int i = 0; i < 8; i++) b[8] += b[i];
		for (int i = 0; i < 9; i++) wb(1'b1, ADDR_FRAME, {24'h0, b[i]});
		do
		begin
			wb(1'b0, ADDR_STATUS, 32'h0);
			n++;
		end
		while (rd[ST_REPLY_BIT] !== 1'b1 && n < 40);
		if (n >= 40) err_count++;
		wb(1'b0, ADDR_REPLY_HDR, 32'h0);
		check("reply header", rd, {8'h02, 8'h01, st, ins});
		wb(1'b0, ADDR_REPLY_VAL, 32'h0);
		val = rd;
		c = 8'h03 + st + ins + val[31:24] + val[23:16];
		c = c + val[15:8] + val[7:0];
		wb(1'b0, ADDR_REPLY_CHK, 32'h0);
		check("reply checksum", rd, {24'h0, c});
		wb(1'b1, ADDR_STATUS, 32'h1);
	endtask : frame
	initial
	begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		summarize();
	end
	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check("pull-ups at reset", pull, 6'h3F);
		wb(1'b1, ADDR_UVAR_SEL, 32'h6);
		wb(1'b1, ADDR_UVAR_DATA, 32'h1234);
		wb(1'b1, ADDR_UVAR_SEL, 32'h5);
		wb(1'b0, ADDR_UVAR_DATA, 32'h0);
		check("boot reload", rd, 32'hA5000005);
		wb(1'b1, ADDR_UVAR_SEL, 32'h6);
		frame(INSTR_STORE_UV, 8'h06, BANK_UVAR, 32'hDEAD, STAT_OK, 8'h00);
		wb(1'b1, ADDR_UVAR_DATA, 32'h0);
		frame(INSTR_RESTORE_UV, 8'h06, BANK_UVAR, 32'h7, STAT_OK, 8'h00);
		wb(1'b0, ADDR_UVAR_DATA, 32'h0);
		check("restored var", rd, 32'h1234);
		$display("test user variables done");
		frame(INSTR_HOMING, HOME_START, MOTOR_ZERO, 32'h5, STAT_OK, 8'h00);
		check("start value", val, 32'h0);
		frame(INSTR_HOMING, HOME_STOP, MOTOR_ZERO, 32'h0, STAT_OK, 8'h00);
		check("pulses", {starts[15:0], stops[15:0]}, 32'h00010001);
		hact <= 1'b1;
		frame(INSTR_HOMING, HOME_STATUS, MOTOR_ZERO, 32'h0, STAT_OK, 8'h00);
		check("active query", {31'h0, val != 32'h0}, 32'h1);
		hact <= 1'b0;
		frame(INSTR_HOMING, HOME_STATUS, MOTOR_ZERO, 32'h0, STAT_OK, 8'h00);
		check("idle query", val, 32'h0);
		$display("test homing done");
		for (int p = 0; p < 8; p++)
		begin
			frame(INSTR_SET_OUT, p[7:0], BANK_OUTPUTS, 32'h1, STAT_OK, 8'h00);
			check("single output", dout, (2 << p) - 1);
		end
		for (int i = 0; i < 3; i++) wb(1'b1, ADDR_FRAME, 32'h77);
		wb(1'b1, ADDR_STATUS, 32'h2);
		frame(INSTR_SET_OUT, PORT_ALL, BANK_OUTPUTS, 32'h5A, STAT_OK, 8'h00);
		check("all outputs", dout, 8'h5A);
		accum <= 32'h000001C3;
		frame(INSTR_SET_OUT, PORT_ALL, BANK_OUTPUTS, VALUE_FROM_ACCUM, STAT_OK,
			8'h00);
		check("outputs from accumulator", dout, 8'hC3);
		frame(INSTR_SET_OUT, PORT_PULLUP, BANK_PULLUP, 32'h15, STAT_OK, 8'h00);
		check("pull-up vector", pull, 6'h15);
		frame(INSTR_SET_OUT, 8'h02, BANK_OUTPUTS, 32'h0, STAT_CHK_ERR, 8'h01);
		check("bad checksum ignored", dout, 8'hC3);
		$display("test outputs done");
		summarize();
	end
endmodule : uho_cmd_top_test
